/* File: logic/ldfs_hyst.sv */
// Purpose: Low-side hysteresis flag on an 8-bit code.
// Assumes: Code is synchronous to clk.
// Notes:   Sets below SET_BELOW, clears above CLEAR_ABOVE, holds between.
`timescale 1ns/1ps
`default_nettype none
module ldfs_hyst #(
   parameter logic [7:0] SET_BELOW   = 8'h10,
   parameter logic [7:0] CLEAR_ABOVE = 8'h20
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] code,
   output logic            flag
);
   logic next_flag;

   // Refused at elaboration; with inverted thresholds the set test wins and no hold band is left
   if (SET_BELOW > CLEAR_ABOVE)
   begin : g_bad_thresholds
      $error("ldfs_hyst: set threshold above clear threshold");
   end

   always_comb
   begin
      next_flag = flag;
      if (code < SET_BELOW)
      begin
         next_flag = 1'b1;
      end
      else if (code > CLEAR_ABOVE)
      begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
      end
   end

   property p_hyst_set;
      @(posedge clk) disable iff (!reset_n)
      (code < SET_BELOW) |=> flag;
   endproperty
   a_hyst_set: assert property (p_hyst_set) else $error("flag not set below threshold");

   property p_hyst_clr;
      @(posedge clk) disable iff (!reset_n)
      (code > CLEAR_ABOVE) |=> !flag;
   endproperty
   a_hyst_clr: assert property (p_hyst_clr) else $error("flag not cleared above threshold");
endmodule : ldfs_hyst
`default_nettype wire

/* File: logic/ldfs_pkg.sv */
// Purpose: Constants for the loop converter fault status word.
// Assumes: 8-bit converter codes, 100 MHz clock.
// Notes:   Thresholds are converter codes derived from the transfer functions.
package ldfs_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned CODE_W         = 8;
   localparam int unsigned WORD_W         = 16;
   localparam int unsigned ADDR_W         = 8;
   // Fault word bit positions
   localparam int unsigned BIT_LINK       = 15;
   localparam int unsigned BIT_FRAME      = 14;
   localparam int unsigned BIT_ILOOP_HI   = 13;
   localparam int unsigned BIT_ILOOP_LO   = 12;
   localparam int unsigned BIT_TEMP_HOT   = 11;
   localparam int unsigned BIT_TEMP_WARM  = 10;
   localparam int unsigned BIT_SUP_SEVERE = 9;
   localparam int unsigned BIT_SUP_WARN   = 8;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   // Temperature: code = (312 - T) / 1.559, hot means low code
   localparam int unsigned TEMP_OFS       = 312;
   localparam int unsigned TEMP_SLOPE_M   = 1559;
   localparam int unsigned TEMP_HOT_SET_C  = 140;
   localparam int unsigned TEMP_HOT_CLR_C  = 125;
   localparam int unsigned TEMP_WARM_SET_C = 100;
   localparam int unsigned TEMP_WARM_CLR_C = 85;
   localparam logic [7:0] HOT_SET  = 8'((TEMP_OFS - TEMP_HOT_SET_C) * 1000 / TEMP_SLOPE_M);
   localparam logic [7:0] HOT_CLR  = 8'((TEMP_OFS - TEMP_HOT_CLR_C) * 1000 / TEMP_SLOPE_M);
   localparam logic [7:0] WARM_SET = 8'((TEMP_OFS - TEMP_WARM_SET_C) * 1000 / TEMP_SLOPE_M);
   localparam logic [7:0] WARM_CLR = 8'((TEMP_OFS - TEMP_WARM_CLR_C) * 1000 / TEMP_SLOPE_M);
   // Loop voltage: code = mV * 256 / 2500
   localparam int unsigned VREF_MV        = 2500;
   localparam int unsigned CODE_SPAN      = 256;
   localparam int unsigned SUP_SEV_SET_MV = 300;
   localparam int unsigned SUP_SEV_CLR_MV = 400;
   localparam int unsigned SUP_WRN_SET_MV = 600;
   localparam int unsigned SUP_WRN_CLR_MV = 700;
   localparam logic [7:0] SEV_SET = 8'(SUP_SEV_SET_MV * CODE_SPAN / VREF_MV);
   localparam logic [7:0] SEV_CLR = 8'(SUP_SEV_CLR_MV * CODE_SPAN / VREF_MV);
   localparam logic [7:0] WRN_SET = 8'(SUP_WRN_SET_MV * CODE_SPAN / VREF_MV);
   localparam logic [7:0] WRN_CLR = 8'(SUP_WRN_CLR_MV * CODE_SPAN / VREF_MV);
endpackage : ldfs_pkg

/* File: logic/ldfs_status.sv */
// Purpose: Fault status word with link timer, flags, alert and alarm drive.
// Assumes: Frame decoder gives strobes; converter codes arrive as samples.
// Notes:   Word is read only; reads answer one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ldfs_status #(
   parameter int unsigned           TMR_W      = 24,
   parameter logic [ldfs_pkg::ADDR_W-1:0] FAULT_ADDR = 8'h05
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   // Frame decoder side
   input  wire logic                        valid_frame,
   input  wire logic                        crc_error,
   input  wire logic [TMR_W-1:0]            timeout_limit,
   input  wire logic                        reg_rd,
   input  wire logic                        reg_wr,
   input  wire logic [ldfs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [ldfs_pkg::WORD_W-1:0] reg_wdata,
   output logic [ldfs_pkg::WORD_W-1:0]      rd_data,
   output logic                             rd_valid,
   // Control register bits
   input  wire logic                        ctrl_alarm_disable,
   input  wire logic                        ctrl_adc_temp_sel,
   // Analog front end
   input  wire logic                        loop_over_in,
   input  wire logic                        loop_under_in,
   input  wire logic                        adc_sample,
   input  wire logic [7:0]                  temp_code,
   input  wire logic [7:0]                  loop_code,
   input  wire logic                        alarm_dir_pin,
   // Outputs
   output logic                             fault_alert,
   output logic                             alarm_current_en,
   output logic                             alarm_upscale
);
   logic [TMR_W-1:0] tmr_cnt;
   logic [TMR_W-1:0] next_tmr_cnt;
   logic             link_timeout_flag;
   logic             next_link_timeout_flag;
   logic             frame_check_error_flag;
   logic             next_frame_check_error_flag;
   logic             loop_current_high_flag;
   logic             loop_current_low_flag;
   logic [7:0]       adc_value;
   logic [7:0]       next_adc_value;
   logic [7:0]       temp_last;
   logic [7:0]       loop_last;
   logic [7:0]       next_temp_last;
   logic [7:0]       next_loop_last;
   logic             temp_hot_flag;
   logic             temp_warm_flag;
   logic             supply_low_severe_flag;
   logic             supply_low_warn_flag;
   logic [ldfs_pkg::WORD_W-1:0] fault_word;
   logic [ldfs_pkg::WORD_W-1:0] next_rd_data;
   logic             next_rd_valid;
   logic             next_alert;
   logic             next_alarm_en;
   logic             rd_hit;
   logic             expired;

   if (TMR_W < 2 || TMR_W > 32)
   begin : g_bad_tmr_w
      $error("ldfs_status: TMR_W out of range");
   end

   assign rd_hit  = reg_rd && (reg_addr == FAULT_ADDR);
   assign expired = (tmr_cnt >= timeout_limit);

   // Link timer and frame flags; a CRC error wins over a same-cycle read clear, a valid frame wins over expiry
   always_comb
   begin
      next_tmr_cnt = tmr_cnt;
      if (valid_frame)
      begin
         next_tmr_cnt = '0;
      end
      else if (!expired)
      begin
         next_tmr_cnt = tmr_cnt + TMR_W'(1);
      end
      next_link_timeout_flag = link_timeout_flag;
      if (valid_frame)
      begin
         next_link_timeout_flag = 1'b0;
      end
      else if (expired)
      begin
         next_link_timeout_flag = 1'b1;
      end
      next_frame_check_error_flag = frame_check_error_flag;
      if (crc_error)
      begin
         next_frame_check_error_flag = 1'b1;
      end
      else if (rd_hit && !reg_wr)
      begin
         // Refused reads must not clear the flag
         next_frame_check_error_flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tmr_cnt                <= '0;
         link_timeout_flag      <= 1'b0;
         frame_check_error_flag <= 1'b0;
      end
      else
      begin
         tmr_cnt                <= next_tmr_cnt;
         link_timeout_flag      <= next_link_timeout_flag;
         frame_check_error_flag <= next_frame_check_error_flag;
      end
   end

   // Converter samples; codes are held so hysteresis sees stable values
   always_comb
   begin
      next_temp_last = temp_last;
      next_loop_last = loop_last;
      next_adc_value = adc_value;
      if (adc_sample)
      begin
         next_temp_last = temp_code;
         next_loop_last = loop_code;
         next_adc_value = ctrl_adc_temp_sel ? temp_code : loop_code;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         temp_last <= 8'hFF;
         loop_last <= 8'hFF;
         adc_value <= 8'h00;
      end
      else
      begin
         temp_last <= next_temp_last;
         loop_last <= next_loop_last;
         adc_value <= next_adc_value;
      end
   end

   ldfs_hyst #(.SET_BELOW(ldfs_pkg::HOT_SET), .CLEAR_ABOVE(ldfs_pkg::HOT_CLR)) u_hot (
      .clk     (clk),
      .reset_n (reset_n),
      .code    (temp_last),
      .flag    (temp_hot_flag)
   );
   ldfs_hyst #(.SET_BELOW(ldfs_pkg::WARM_SET), .CLEAR_ABOVE(ldfs_pkg::WARM_CLR)) u_warm (
      .clk     (clk),
      .reset_n (reset_n),
      .code    (temp_last),
      .flag    (temp_warm_flag)
   );
   ldfs_hyst #(.SET_BELOW(ldfs_pkg::SEV_SET), .CLEAR_ABOVE(ldfs_pkg::SEV_CLR)) u_sev (
      .clk     (clk),
      .reset_n (reset_n),
      .code    (loop_last),
      .flag    (supply_low_severe_flag)
   );
   ldfs_hyst #(.SET_BELOW(ldfs_pkg::WRN_SET), .CLEAR_ABOVE(ldfs_pkg::WRN_CLR)) u_wrn (
      .clk     (clk),
      .reset_n (reset_n),
      .code    (loop_last),
      .flag    (supply_low_warn_flag)
   );

   always_comb
   begin
      fault_word = ldfs_pkg::WORD_RESET;
      fault_word[ldfs_pkg::BIT_LINK]       = link_timeout_flag;
      fault_word[ldfs_pkg::BIT_FRAME]      = frame_check_error_flag;
      fault_word[ldfs_pkg::BIT_ILOOP_HI]   = loop_current_high_flag;
      fault_word[ldfs_pkg::BIT_ILOOP_LO]   = loop_current_low_flag;
      fault_word[ldfs_pkg::BIT_TEMP_HOT]   = temp_hot_flag;
      fault_word[ldfs_pkg::BIT_TEMP_WARM]  = temp_warm_flag;
      fault_word[ldfs_pkg::BIT_SUP_SEVERE] = supply_low_severe_flag;
      fault_word[ldfs_pkg::BIT_SUP_WARN]   = supply_low_warn_flag;
      fault_word[7:0]                      = adc_value;
   end

   // Warning bits stay off the alert pin by design
   always_comb
   begin
      next_alert = link_timeout_flag || frame_check_error_flag ||
                   loop_current_high_flag || loop_current_low_flag ||
                   temp_hot_flag || supply_low_severe_flag;
      next_alarm_en = link_timeout_flag && !ctrl_alarm_disable;
      // Writes never reach the word; data bus is deliberately unused
      next_rd_valid = rd_hit && !reg_wr;
      next_rd_data  = next_rd_valid ? fault_word : rd_data;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         loop_current_high_flag <= 1'b0;
         loop_current_low_flag  <= 1'b0;
         fault_alert            <= 1'b0;
         alarm_current_en       <= 1'b0;
         alarm_upscale          <= 1'b0;
         rd_valid               <= 1'b0;
         rd_data                <= ldfs_pkg::WORD_RESET;
      end
      else
      begin
         loop_current_high_flag <= loop_over_in;
         loop_current_low_flag  <= loop_under_in;
         fault_alert            <= next_alert;
         alarm_current_en       <= next_alarm_en;
         alarm_upscale          <= alarm_dir_pin;
         rd_valid               <= next_rd_valid;
         rd_data                <= next_rd_data;
      end
   end

   logic unused_wdata;
   assign unused_wdata = ^reg_wdata;

   property p_link_set;
      @(posedge clk) disable iff (!reset_n)
      (expired && !valid_frame) |=> link_timeout_flag ##1 fault_alert;
   endproperty
   a_link_set: assert property (p_link_set) else $error("link timeout not flagged");

   property p_alarm;
      @(posedge clk) disable iff (!reset_n)
      (link_timeout_flag && !ctrl_alarm_disable) |=> alarm_current_en;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm current not driven");

   property p_alarm_dir;
      @(posedge clk) disable iff (!reset_n)
      alarm_dir_pin |=> alarm_upscale;
   endproperty
   a_alarm_dir: assert property (p_alarm_dir) else $error("alarm direction wrong");

   property p_crc;
      @(posedge clk) disable iff (!reset_n)
      crc_error |=> frame_check_error_flag ##1 fault_alert;
   endproperty
   a_crc: assert property (p_crc) else $error("frame error lost");

   property p_over;
      @(posedge clk) disable iff (!reset_n)
      loop_over_in |=> loop_current_high_flag ##1 fault_alert;
   endproperty
   a_over: assert property (p_over) else $error("over current not flagged");

   property p_under;
      @(posedge clk) disable iff (!reset_n)
      loop_under_in |=> loop_current_low_flag ##1 fault_alert;
   endproperty
   a_under: assert property (p_under) else $error("under current not flagged");

   property p_warn_quiet;
      @(posedge clk) disable iff (!reset_n)
      (fault_word[15:8] == 8'h05) |=> !fault_alert;
   endproperty
   a_warn_quiet: assert property (p_warn_quiet) else $error("warning raised alert");

   property p_adc;
      @(posedge clk) disable iff (!reset_n)
      (adc_sample && ctrl_adc_temp_sel) |=> adc_value == $past(temp_code);
   endproperty
   a_adc: assert property (p_adc) else $error("converter code not selected");

   property p_read;
      @(posedge clk) disable iff (!reset_n)
      (rd_hit && !reg_wr) |=> rd_valid && rd_data == $past(fault_word);
   endproperty
   a_read: assert property (p_read) else $error("fault word read wrong");

   property p_write;
      @(posedge clk) disable iff (!reset_n)
      (reg_wr && !reg_rd) |=> !rd_valid && $stable(rd_data);
   endproperty
   a_write: assert property (p_write) else $error("write affected fault word");
endmodule : ldfs_status
`default_nettype wire

/* File: tb/ldfs_host_model.sv */
// Purpose: Host side model issuing register frames to the status block.
// Assumes: Requests change 1 ns after the rising edge.
// Notes:   Released address and data lines show the inverse of their last value; strobes return low.
`timescale 1ns/1ps
`default_nettype none
module ldfs_host_model (
   input  wire logic                        clk,
   input  wire logic [ldfs_pkg::WORD_W-1:0] rd_data,
   input  wire logic                        rd_valid,
   output logic                             reg_rd,
   output logic                             reg_wr,
   output logic [ldfs_pkg::ADDR_W-1:0]      reg_addr,
   output logic [ldfs_pkg::WORD_W-1:0]      reg_wdata,
   output logic                             valid_frame,
   output logic                             crc_error
);
   initial
   begin
      reg_rd      = 1'b0;
      reg_wr      = 1'b0;
      reg_addr    = 8'h00;
      reg_wdata   = 16'h0000;
      valid_frame = 1'b0;
      crc_error   = 1'b0;
   end

   // Answer taken one edge after the request edge
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      @(posedge clk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      ok       = rd_valid;
      d        = rd_data;
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr

   // A frame failing its check is never also a valid frame
   task automatic frame(input logic bad);
      @(posedge clk);
      #1;
      valid_frame = ~bad;
      crc_error   = bad;
      @(posedge clk);
      #1;
      valid_frame = 1'b0;
      crc_error   = 1'b0;
   endtask : frame
endmodule : ldfs_host_model
`default_nettype wire

/* File: tb/ldfs_status_tb_top.sv */
// Purpose: Self-checking bench for the fault status word.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Codes stay clear of thresholds except where hysteresis is probed.
`timescale 1ns/1ps
`default_nettype none
module ldfs_status_tb_top;
   logic        clk;
   logic        reset_n;
   logic [23:0] timeout_limit;
   logic        ctrl_alarm_disable;
   logic        ctrl_adc_temp_sel;
   logic        loop_over_in;
   logic        loop_under_in;
   logic        adc_sample;
   logic [7:0]  temp_code;
   logic [7:0]  loop_code;
   logic        alarm_dir_pin;
   logic        valid_frame;
   logic        crc_error;
   logic        reg_rd;
   logic        reg_wr;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic        fault_alert;
   logic        alarm_current_en;
   logic        alarm_upscale;
   int          failures;
   int          checks_done;
   logic [15:0] d;
   logic        ok;
   int          n;

   ldfs_status #(.TMR_W(24), .FAULT_ADDR(8'h05)) i_ldfs_status (
      .clk(clk), .reset_n(reset_n), .valid_frame(valid_frame), .crc_error(crc_error),
      .timeout_limit(timeout_limit), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .ctrl_alarm_disable(ctrl_alarm_disable), .ctrl_adc_temp_sel(ctrl_adc_temp_sel),
      .loop_over_in(loop_over_in), .loop_under_in(loop_under_in), .adc_sample(adc_sample),
      .temp_code(temp_code), .loop_code(loop_code), .alarm_dir_pin(alarm_dir_pin),
      .fault_alert(fault_alert), .alarm_current_en(alarm_current_en),
      .alarm_upscale(alarm_upscale));

   ldfs_host_model i_ldfs_host_model (
      .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .valid_frame(valid_frame),
      .crc_error(crc_error));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   // Alert looked at before the read, since a read may clear bit 14
   task automatic rdchk(input logic [15:0] e, input logic al);
      logic [15:0] w;
      logic        v;
      check("fault_alert", {15'h0000, al}, {15'h0000, fault_alert});
      i_ldfs_host_model.rd(8'h05, w, v);
      check("rd_valid", 16'h0001, {15'h0000, v});
      check("fault word", e, w);
   endtask : rdchk

   task automatic adc(input logic s, input logic [7:0] lc, input logic [7:0] tc,
                      input logic [15:0] e, input logic al);
      ctrl_adc_temp_sel = s;
      loop_code         = lc;
      temp_code         = tc;
      adc_sample        = 1'b1;
      tick(1);
      adc_sample        = 1'b0;
      tick(3);
      rdchk(e, al);
   endtask : adc

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   initial
   begin
      failures = 0;
      checks_done = 0;
      reset_n = 1'b0;
      timeout_limit = 24'h00_1000;
      ctrl_alarm_disable = 1'b0;
      ctrl_adc_temp_sel = 1'b0;
      loop_over_in = 1'b0;
      loop_under_in = 1'b0;
      adc_sample = 1'b0;
      temp_code = 8'hff;
      loop_code = 8'hff;
      alarm_dir_pin = 1'b0;
      tick(10);
      reset_n = 1'b1;
      rdchk(16'h0000, 1'b0);
      i_ldfs_host_model.wr(8'h05, 16'hffff);
      tick(2);
      rdchk(16'h0000, 1'b0);
      i_ldfs_host_model.rd(8'h06, d, ok);
      check("unmapped rd_valid", 16'h0000, {15'h0000, ok});
      i_ldfs_host_model.frame(1'b1);
      tick(3);
      i_ldfs_host_model.wr(8'h05, 16'h0000);
      tick(1);
      rdchk(16'h4000, 1'b1);
      tick(2);
      rdchk(16'h0000, 1'b0);
      loop_over_in = 1'b1;
      tick(3);
      rdchk(16'h2000, 1'b1);
      loop_over_in = 1'b0;
      loop_under_in = 1'b1;
      tick(3);
      rdchk(16'h1000, 1'b1);
      loop_under_in = 1'b0;
      tick(3);
      rdchk(16'h0000, 1'b0);
      adc(1'b0, 8'h14, 8'hc8, 16'h0314, 1'b1);
      adc(1'b0, 8'h23, 8'hc8, 16'h0323, 1'b1);
      adc(1'b0, 8'h32, 8'hc8, 16'h0132, 1'b0);
      adc(1'b0, 8'h64, 8'hc8, 16'h0064, 1'b0);
      adc(1'b1, 8'h64, 8'h64, 16'h0c64, 1'b1);
      adc(1'b1, 8'h64, 8'h73, 16'h0c73, 1'b1);
      adc(1'b1, 8'h64, 8'h8c, 16'h048c, 1'b0);
      adc(1'b1, 8'h3c, 8'h82, 16'h0582, 1'b0);
      adc(1'b1, 8'h64, 8'hc8, 16'h00c8, 1'b0);
      // Timer has run far past a short limit without any valid frame
      timeout_limit = 24'h00_000a;
      tick(4);
      rdchk(16'h80c8, 1'b1);
      check("alarm_current_en", 16'h0001, {15'h0000, alarm_current_en});
      alarm_dir_pin = 1'b1;
      tick(2);
      check("alarm_upscale", 16'h0001, {15'h0000, alarm_upscale});
      alarm_dir_pin = 1'b0;
      ctrl_alarm_disable = 1'b1;
      tick(2);
      check("alarm_upscale", 16'h0000, {15'h0000, alarm_upscale});
      check("alarm_current_en", 16'h0000, {15'h0000, alarm_current_en});
      ctrl_alarm_disable = 1'b0;
      i_ldfs_host_model.frame(1'b0);
      tick(1);
      rdchk(16'h00c8, 1'b0);
      n = 0;
      while (fault_alert !== 1'b1 && n < 100)
      begin
         tick(1);
         n++;
      end
      if (n >= 100)
      begin
         failures++;
         $display("ERROR alert wait expected %0d seen %0d", 10, n);
      end
      check("timeout span", 16'h0001, {15'h0000, (n >= 5 && n <= 10)});
      reset_n = 1'b0;
      #1;
      check("alert in reset", 16'h0000, {15'h0000, fault_alert});
      tick(2);
      reset_n = 1'b1;
      rdchk(16'h0000, 1'b0);
      final_report();
   end
endmodule : ldfs_status_tb_top
`default_nettype wire
